// ### ftc_interp.sv
// Period-based count extension: fraction = 32 * since / between
`timescale 1ns/1ps
module ftc_interp (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        start_i,
    input  wire logic [15:0] since_i,
    input  wire logic [15:0] between_i,
    output logic      [4:0]  frac_o,
    output logic             done_o
);
    import ftc_pkg::*;

    logic [16:0] rem_q;
    logic [4:0]  quo_q;
    logic [2:0]  cnt_q;
    logic        busy_q;
    logic [16:0] rem_sh;

    assign rem_sh = {rem_q[15:0], 1'b0};
    assign frac_o = quo_q;

    // ==========================================================
    // Restoring divider, one fraction bit per cycle
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rem_q  <= '0;
            quo_q  <= '0;
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                rem_q  <= {1'b0, since_i};
                quo_q  <= '0;
                cnt_q  <= 3'(FRAC_BITS);
                busy_q <= 1'b1;
                // Saturate rather than wrap when the count is overdue
                if (between_i == 16'h0000 || since_i >= between_i) begin
                    quo_q  <= 5'h1F;
                    busy_q <= 1'b0;
                    done_o <= 1'b1;
                end
            end else if (busy_q) begin
                if (rem_sh >= {1'b0, between_i}) begin
                    rem_q <= rem_sh - {1'b0, between_i};
                    quo_q <= {quo_q[3:0], 1'b1};
                end else begin
                    rem_q <= rem_sh;
                    quo_q <= {quo_q[3:0], 1'b0};
                end
                cnt_q <= cnt_q - 3'd1;
                if (cnt_q == 3'd1) begin
                    busy_q <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule : ftc_interp

// ### ftc_par_read.sv
// Parallel-read conversion: mask, optional slew limit, shift
`timescale 1ns/1ps
module ftc_par_read (
    input  wire logic [ftc_pkg::DW-1:0] raw_i,
    input  wire logic [ftc_pkg::DW-1:0] mask_i,
    input  wire logic [ftc_pkg::DW-1:0] maxc_i,
    input  wire logic [ftc_pkg::DW-1:0] held_i,
    input  wire logic [3:0]             shift_i,
    input  wire logic                   filt_i,
    output logic      [ftc_pkg::DW-1:0] held_o,
    output logic      [ftc_pkg::DW-1:0] result_o
);
    import ftc_pkg::*;

    logic        [DW-1:0] masked;
    logic signed [DW-1:0] delta;
    logic signed [DW-1:0] lim;

    // ==========================================================
    // Slew limit
    always_comb begin
        masked = raw_i & mask_i;
        delta  = $signed(masked - held_i);
        lim    = delta;
        if (delta > $signed(maxc_i)) begin
            lim = $signed(maxc_i);
        end else if (delta < -$signed(maxc_i)) begin
            lim = -$signed(maxc_i);
        end
        // Bad echoes move the output by at most the limit per cycle
        held_o = filt_i ? held_i + DW'(lim) : masked;
    end

    // ==========================================================
    // Shift
    always_comb begin
        case (shift_i & 4'hE)
            SH_NONE:  result_o = held_o;
            SH_RIGHT: result_o = DW'($signed(held_o) >>> SH_RIGHT_BITS);
            default:  result_o = held_o << SH_LEFT_BITS;
        endcase
    end
endmodule : ftc_par_read

// ### ftc_pkg.sv
// Shared constants, types and helpers of the feedback and time-base conversion block
package ftc_pkg;
    // ==========================================================
    // Widths
    localparam int DW = 24;
    localparam int AW = 8;

    // ==========================================================
    // Register offsets
    localparam logic [AW-1:0] OFF_PAR_SETUP = 8'h00;
    localparam logic [AW-1:0] OFF_PAR_MASK  = 8'h04;
    localparam logic [AW-1:0] OFF_PAR_MAXC  = 8'h08;
    localparam logic [AW-1:0] OFF_PAR_RES   = 8'h0C;
    localparam logic [AW-1:0] OFF_TB_SETUP  = 8'h10;
    localparam logic [AW-1:0] OFF_TB_SCALE  = 8'h14;
    localparam logic [AW-1:0] OFF_TB_PREV   = 8'h18;
    localparam logic [AW-1:0] OFF_TB_RES    = 8'h1C;
    localparam logic [AW-1:0] OFF_XDCR_TIME = 8'h20;

    // ==========================================================
    // Reset values
    localparam logic [DW-1:0] RST_PAR_SETUP = 24'h60_0000;
    localparam logic [DW-1:0] RST_PAR_MASK  = 24'hFF_FFFF;
    localparam logic [DW-1:0] RST_PAR_MAXC  = 24'h00_0400;
    localparam logic [DW-1:0] RST_TB_SETUP  = 24'h90_0000;
    localparam logic [DW-1:0] RST_TB_SCALE  = 24'h00_0200;

    // ==========================================================
    // Method and shift digits
    localparam logic [3:0] M_Y_RAW  = 4'h2;
    localparam logic [3:0] M_Y_FILT = 4'h3;
    localparam logic [3:0] M_TB     = 4'h4;
    localparam logic [3:0] M_X_RAW  = 4'h6;
    localparam logic [3:0] M_X_FILT = 4'h7;
    localparam logic [3:0] M_FROZEN = 4'h9;
    localparam logic [3:0] M_RUN    = 4'hA;
    localparam logic [3:0] M_ARMED  = 4'hB;
    localparam logic [3:0] SH_NORM  = 4'h0;
    localparam logic [3:0] SH_NONE  = 4'h8;
    localparam logic [3:0] SH_RIGHT = 4'hC;
    localparam int SH_LEFT_BITS  = 5;
    localparam int SH_RIGHT_BITS = 3;

    // ==========================================================
    // Source map and timing
    localparam logic [15:0] TIMER_ADDR     = 16'hFF00;
    localparam logic [15:0] CAP_OFFSET     = 16'h0003;
    localparam int          FRAC_BITS      = 5;
    localparam int          CLK_MHZ        = 125;
    localparam int          TIMER_MHZ      = 120;
    localparam int          EXCITE_NS      = 1000;
    localparam int          EXCITE_CYC     = (EXCITE_NS * CLK_MHZ) / 1000;
    localparam int          SERVO_NS       = 442000;
    localparam int          SERVO_CYC_DEF  = (SERVO_NS * CLK_MHZ) / 1000;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [3:0]  method;
        logic [3:0]  shift;
        logic [15:0] addr;
    } ftc_setup_t;

    typedef struct packed {
        logic        rd;
        logic        xside;
        logic [15:0] addr;
    } ftc_src_req_t;

    typedef enum {S_IDLE, S_PAR_W, S_TB_W, S_CAP_W, S_DIV, S_CALC} ftc_seq_t;

    // Truncated 2 * scale * difference, shared by the untriggered and running modes
    function automatic logic [DW-1:0] ftc_scale_diff(input logic [DW-1:0] scale,
                                                     input logic [DW-1:0] diff);
        logic signed [2*DW-1:0] prod;
        prod = $signed(scale) * $signed(diff);
        return {prod[DW-2:0], 1'b0};
    endfunction : ftc_scale_diff
endpackage : ftc_pkg

// ### ftc_properties.sv
// Port timing checks for the conversion block
`timescale 1ns/1ps
module ftc_properties #(
    parameter int SERVO_CYC = 64
) (
    input wire logic                   ref_clk_i,
    input wire logic                   sys_rst_i,
    input wire logic                   reg_rd_i,
    input wire logic [ftc_pkg::DW-1:0] reg_rdata_o,
    input ftc_pkg::ftc_src_req_t       src_req_o,
    input wire logic                   servo_tick_o,
    input wire logic                   magnetostrictive_transducer_excite_o,
    input wire logic [ftc_pkg::DW-1:0] coord_timebase_pointer_o
);
    import ftc_pkg::*;
    int   cnt_q;
    int   ex_q;
    logic seen_q;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Cycles since the last tick; seen_q masks the unknown phase before the first
    always_ff @(posedge ref_clk_i) begin
        cnt_q  <= (sys_rst_i || servo_tick_o) ? 0 : cnt_q + 1;
        ex_q   <= (!sys_rst_i && magnetostrictive_transducer_excite_o) ? ex_q + 1 : 0;
        seen_q <= !sys_rst_i && (seen_q || servo_tick_o);
    end
    a_tick_period: assert property (servo_tick_o && seen_q |-> cnt_q == SERVO_CYC - 1)
        else $error("servo tick spacing wrong");
    a_read_burst: assert property (servo_tick_o |=> src_req_o.rd ##1 src_req_o.rd)
        else $error("source reads missing after tick");
    a_read_window: assert property (src_req_o.rd |-> seen_q && cnt_q <= 2)
        else $error("source read outside burst");
    a_tb_xside: assert property (src_req_o.rd && cnt_q inside {1, 2} |-> src_req_o.xside)
        else $error("time base read not X side");
    a_excite_start: assert property ($rose(magnetostrictive_transducer_excite_o) |-> $past(servo_tick_o))
        else $error("excitation not started by tick");
    a_excite_width: assert property ($fell(magnetostrictive_transducer_excite_o) |-> ex_q == EXCITE_CYC)
        else $error("excitation width wrong");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside answer cycle");
    a_tb_window: assert property (!$stable(coord_timebase_pointer_o) |-> seen_q && cnt_q < 20)
        else $error("time base result moved off cycle");
    c_capture: cover property (src_req_o.rd && cnt_q == 2);
    c_excite: cover property ($fell(magnetostrictive_transducer_excite_o));
    c_rate: cover property (!$stable(coord_timebase_pointer_o));
endmodule : ftc_properties

bind ftc_top ftc_properties #(.SERVO_CYC(SERVO_CYC)) u_props (.ref_clk_i, .sys_rst_i, .reg_rd_i, .reg_rdata_o,
    .src_req_o, .servo_tick_o, .magnetostrictive_transducer_excite_o, .coord_timebase_pointer_o);

// ### ftc_source_model.sv
// Far side: source words, capture register and transducer echo
`timescale 1ns/1ps
module ftc_source_model (
    input  wire logic             clk_i,
    input  ftc_pkg::ftc_src_req_t req_i,
    input  wire logic [23:0]      x_i,
    input  wire logic [23:0]      y_i,
    input  wire logic [23:0]      cap_i,
    input  wire logic             excite_i,
    output logic      [23:0]      data_o,
    output logic                  echo_o
);
    logic [7:0]  ec_q = 8'h00;
    logic [23:0] word;
    initial echo_o = 1'b0;
    // Word stands only while the read strobe does; otherwise its inverse, so a mistimed sample is caught
    assign word   = !req_i.xside ? y_i : (req_i.addr[1:0] == 2'd3) ? cap_i : x_i;
    assign data_o = req_i.rd ? word : ~word;
    // Excitation is unknown before the first reset edge
    always @(posedge clk_i) begin
        ec_q   <= (excite_i === 1'b1 || ec_q != 8'h00) ? ec_q + 8'h01 : 8'h00;
        echo_o <= ec_q > 8'h63 && ec_q < 8'h68;
    end
endmodule : ftc_source_model

// ### ftc_top.sv
// Servo-cycle conversion entries: one parallel read, one time base, transducer timer
//
// How it works
// - X-side node word read unfiltered; no-shift digit passes it unshifted.
// - Emit excitation pulse, time echo with 120 MHz count, read as absolute.
// - Transducer entry limits per-cycle output change to the third-line value.
// - Latched inputs read as filtered Y words; digit 0 shifts, 8 does not.
// - Time-base entry differentiates and scales its source every servo cycle.
// - Two setup words and two results: saved previous value, final rate.
// - Method 4 in bits 20-23 selects untriggered; source in bits 0-15.
// - Untriggered result is 2 times scale times new minus old source.
// - Triggered uses method 9, A or B; source is channel base address.
// - Running output is 64 times scale times whole-count difference.
// - Triggered count is extended by period interpolation to 1/32 count.
// - Triggered entry has frozen, armed and running states from its method.
// - Frozen entry reads captured position every cycle to rearm capture.
// - Frozen result is forced to zero.
// - Armed entry polls trigger; on it, goes running from captured position.
// - Armed result is held at zero.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module ftc_top #(
    parameter int SERVO_CYC = ftc_pkg::SERVO_CYC_DEF
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic [ftc_pkg::AW-1:0] reg_addr_i,
    input  wire logic [ftc_pkg::DW-1:0] reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [ftc_pkg::DW-1:0] reg_rdata_o,
    output ftc_pkg::ftc_src_req_t       src_req_o,
    input  wire logic [ftc_pkg::DW-1:0] src_data_i,
    input  wire logic                   trig_i,
    input  wire logic [15:0]            enc_since_i,
    input  wire logic [15:0]            enc_between_i,
    output logic                        magnetostrictive_transducer_excite_o,
    input  wire logic                   magnetostrictive_transducer_echo_i,
    output logic                        servo_tick_o,
    output logic      [ftc_pkg::DW-1:0] par_result_o,
    output logic      [ftc_pkg::DW-1:0] coord_timebase_pointer_o
);
    import ftc_pkg::*;

    // ==========================================================
    // Registers and state
    ftc_setup_t    par_setup_q;
    logic [DW-1:0] par_mask_q;
    logic [DW-1:0] par_maxc_q;
    logic [DW-1:0] par_held_q;
    ftc_setup_t    tb_setup_q;
    logic [DW-1:0] rate_scale_word_q;
    logic [DW-1:0] tb_prev_q;
    logic [3:0]    tb_meth_q;
    logic [DW-1:0] par_raw_q;
    logic [DW-1:0] tb_raw_q;
    logic [DW-1:0] cap_raw_q;
    logic [DW-1:0] xdcr_time_q;
    logic [DW-1:0] xdcr_cnt_q;
    logic          xdcr_run_q;
    logic [15:0]   exc_cnt_q;
    logic [7:0]    phase_q;
    logic          tmr_en_q;
    logic [2:0]    echo_sync_q;
    logic [31:0]   tick_cnt_q;
    ftc_seq_t      seq_q;
    logic          div_start_q;

    logic [DW-1:0] par_held_d;
    logic [DW-1:0] par_res_d;
    logic [DW-1:0] par_src;
    logic          trig_entry;
    logic [4:0]    frac;
    logic          div_done;
    logic [DW-1:0] ext_new;
    logic [DW-1:0] ext_cap;
    logic          hw_run;

    assign trig_entry = (tb_meth_q == M_FROZEN) || (tb_meth_q == M_RUN) ||
                        (tb_meth_q == M_ARMED);
    assign par_src    = (par_setup_q.addr == TIMER_ADDR) ? xdcr_time_q : par_raw_q;
    // Extended count in 1/32 count units
    assign ext_new    = {tb_raw_q[DW-FRAC_BITS-1:0], frac};
    assign ext_cap    = {cap_raw_q[DW-FRAC_BITS-1:0], {FRAC_BITS{1'b0}}};
    assign hw_run     = (seq_q == S_CALC) && (tb_meth_q == M_ARMED) && trig_i;

    // ==========================================================
    // Servo cycle divider
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tick_cnt_q   <= '0;
            servo_tick_o <= 1'b0;
        end else begin
            servo_tick_o <= (tick_cnt_q == 32'(SERVO_CYC - 1));
            tick_cnt_q   <= (tick_cnt_q == 32'(SERVO_CYC - 1)) ? '0 : tick_cnt_q + 32'd1;
        end
    end

    // ==========================================================
    // Transducer timer: 120 MHz rate taken from 125 MHz by phase stepping
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            phase_q  <= '0;
            tmr_en_q <= 1'b0;
        end else if (phase_q + 8'(TIMER_MHZ) >= 8'(CLK_MHZ)) begin
            phase_q  <= phase_q + 8'(TIMER_MHZ) - 8'(CLK_MHZ);
            tmr_en_q <= 1'b1;
        end else begin
            phase_q  <= phase_q + 8'(TIMER_MHZ);
            tmr_en_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            echo_sync_q <= '0;
        end else begin
            echo_sync_q <= {echo_sync_q[1:0], magnetostrictive_transducer_echo_i};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            exc_cnt_q                            <= '0;
            magnetostrictive_transducer_excite_o <= 1'b0;
            xdcr_cnt_q                           <= '0;
            xdcr_run_q                           <= 1'b0;
            xdcr_time_q                          <= '0;
        end else begin
            if (servo_tick_o) begin
                exc_cnt_q                            <= 16'(EXCITE_CYC);
                magnetostrictive_transducer_excite_o <= 1'b1;
                xdcr_cnt_q                           <= '0;
                xdcr_run_q                           <= 1'b1;
            end else begin
                if (exc_cnt_q != 16'h0000) begin
                    exc_cnt_q <= exc_cnt_q - 16'd1;
                end
                magnetostrictive_transducer_excite_o <= (exc_cnt_q > 16'd1);
                if (xdcr_run_q && echo_sync_q[1] && !echo_sync_q[2]) begin
                    // Interval to echo is the absolute position
                    xdcr_time_q <= xdcr_cnt_q;
                    xdcr_run_q  <= 1'b0;
                end else if (xdcr_run_q && tmr_en_q) begin
                    xdcr_cnt_q <= xdcr_cnt_q + 24'h00_0001;
                end
            end
        end
    end

    // ==========================================================
    // Sequencer: parallel source, time-base source, capture, interpolate, compute
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            seq_q       <= S_IDLE;
            src_req_o   <= '0;
            tb_meth_q   <= '0;
            div_start_q <= 1'b0;
            par_raw_q   <= '0;
            tb_raw_q    <= '0;
            cap_raw_q   <= '0;
        end else begin
            src_req_o.rd <= 1'b0;
            div_start_q  <= 1'b0;
            case (seq_q)
                S_IDLE: begin
                    if (servo_tick_o) begin
                        // Method sampled once per cycle so a mid-cycle write waits
                        tb_meth_q       <= tb_setup_q.method;
                        src_req_o.rd    <= 1'b1;
                        src_req_o.xside <= (par_setup_q.method == M_X_RAW) ||
                                           (par_setup_q.method == M_X_FILT);
                        src_req_o.addr  <= par_setup_q.addr;
                        seq_q           <= S_PAR_W;
                    end
                end
                S_PAR_W: begin
                    par_raw_q       <= src_data_i;
                    src_req_o.rd    <= 1'b1;
                    src_req_o.xside <= 1'b1;
                    src_req_o.addr  <= tb_setup_q.addr;
                    seq_q           <= S_TB_W;
                end
                S_TB_W: begin
                    tb_raw_q <= src_data_i;
                    if (trig_entry) begin
                        // Reading the capture register rearms the capture logic
                        src_req_o.rd    <= 1'b1;
                        src_req_o.xside <= 1'b1;
                        src_req_o.addr  <= tb_setup_q.addr + CAP_OFFSET;
                        seq_q           <= S_CAP_W;
                    end else begin
                        seq_q <= S_CALC;
                    end
                end
                S_CAP_W: begin
                    cap_raw_q   <= src_data_i;
                    div_start_q <= 1'b1;
                    seq_q       <= S_DIV;
                end
                S_DIV: begin
                    if (div_done) begin
                        seq_q <= S_CALC;
                    end
                end
                S_CALC: begin
                    seq_q <= S_IDLE;
                end
                default: begin
                    seq_q <= S_IDLE;
                end
            endcase
        end
    end

    ftc_interp u_interp (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (div_start_q),
        .since_i   (enc_since_i),
        .between_i (enc_between_i),
        .frac_o    (frac),
        .done_o    (div_done)
    );

    ftc_par_read u_par (
        .raw_i    (par_src),
        .mask_i   (par_mask_q),
        .maxc_i   (par_maxc_q),
        .held_i   (par_held_q),
        .shift_i  (par_setup_q.shift),
        .filt_i   (par_setup_q.method == M_Y_FILT || par_setup_q.method == M_X_FILT),
        .held_o   (par_held_d),
        .result_o (par_res_d)
    );

    // ==========================================================
    // Parallel entry result
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            par_held_q   <= '0;
            par_result_o <= '0;
        end else if (seq_q == S_CALC) begin
            par_held_q   <= par_held_d;
            par_result_o <= par_res_d;
        end
    end

    // ==========================================================
    // Time-base entry results
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tb_prev_q                <= '0;
            coord_timebase_pointer_o <= '0;
        end else if (seq_q == S_CALC) begin
            case (tb_meth_q)
                M_TB: begin
                    tb_prev_q                <= tb_raw_q;
                    coord_timebase_pointer_o <= ftc_scale_diff(rate_scale_word_q,
                                                               tb_raw_q - tb_prev_q);
                end
                M_RUN: begin
                    tb_prev_q                <= ext_new;
                    // 2 * scale per 1/32 count equals 64 * scale per count
                    coord_timebase_pointer_o <= ftc_scale_diff(rate_scale_word_q,
                                                               ext_new - tb_prev_q);
                end
                M_ARMED: begin
                    if (trig_i) begin
                        tb_prev_q <= ext_cap;
                    end
                    coord_timebase_pointer_o <= '0;
                end
                default: begin
                    coord_timebase_pointer_o <= '0;
                end
            endcase
        end
    end

    // ==========================================================
    // Setup registers; a trigger's switch to running beats a same-cycle write
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            par_setup_q       <= RST_PAR_SETUP;
            par_mask_q        <= RST_PAR_MASK;
            par_maxc_q        <= RST_PAR_MAXC;
            tb_setup_q        <= RST_TB_SETUP;
            rate_scale_word_q <= RST_TB_SCALE;
        end else begin
            if (reg_wr_i) begin
                case (reg_addr_i)
                    OFF_PAR_SETUP: par_setup_q       <= reg_wdata_i;
                    OFF_PAR_MASK:  par_mask_q        <= reg_wdata_i;
                    OFF_PAR_MAXC:  par_maxc_q        <= reg_wdata_i;
                    OFF_TB_SETUP:  tb_setup_q        <= reg_wdata_i;
                    OFF_TB_SCALE:  rate_scale_word_q <= reg_wdata_i;
                    default: begin
                    end
                endcase
            end
            if (hw_run) begin
                tb_setup_q.method <= M_RUN;
            end
        end
    end

    // ==========================================================
    // Read port, data one cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                OFF_PAR_SETUP: reg_rdata_o <= par_setup_q;
                OFF_PAR_MASK:  reg_rdata_o <= par_mask_q;
                OFF_PAR_MAXC:  reg_rdata_o <= par_maxc_q;
                OFF_PAR_RES:   reg_rdata_o <= par_result_o;
                OFF_TB_SETUP:  reg_rdata_o <= tb_setup_q;
                OFF_TB_SCALE:  reg_rdata_o <= rate_scale_word_q;
                OFF_TB_PREV:   reg_rdata_o <= tb_prev_q;
                OFF_TB_RES:    reg_rdata_o <= coord_timebase_pointer_o;
                OFF_XDCR_TIME: reg_rdata_o <= xdcr_time_q;
                default:       reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end
endmodule : ftc_top

// ### test_feedback_timebase_convert.sv
// Self-checking bench for the feedback and time-base conversion block
`timescale 1ns/1ps
module test_feedback_timebase_convert;
    import ftc_pkg::*;
    logic          clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, trig = 1'b0, cap_rd = 1'b0;
    logic [AW-1:0] addr = '0;
    logic [15:0]   since = 16'h0008;
    logic [DW-1:0] wdata = '0, xw = '0, yw = '0, cap = '0, sdat, rdat, v, r1, pres, tbres;
    logic          excite, echo, tick;
    ftc_src_req_t  req;
    int            n_fail = 0, num_checks = 0;
    logic [DW-1:0] rows [4][4] = '{'{24'h68_C0A0, 24'h12_3456, 24'h5A_5A5A, 24'h12_3456},
        '{24'h60_C0A4, 24'h00_0321, 24'h5A_5A5A, 24'h00_6420}, '{24'h2C_C0A8, 24'h5A_5A5A, 24'h80_0010, 24'hF0_0002},
        '{24'h20_FFD1, 24'h5A_5A5A, 24'h00_0045, 24'h00_08A0}};
    always #4 clk = ~clk;
    always @(posedge clk) if (req.rd && req.xside && req.addr == 16'hC003) cap_rd <= 1'b1;
    ftc_top #(.SERVO_CYC(256)) dut (.ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .src_req_o(req), .src_data_i(sdat), .trig_i(trig),
        .enc_since_i(since), .enc_between_i(16'h0020), .magnetostrictive_transducer_excite_o(excite),
        .magnetostrictive_transducer_echo_i(echo), .servo_tick_o(tick), .par_result_o(pres),
        .coord_timebase_pointer_o(tbres));
    ftc_source_model u_far (.clk_i(clk), .req_i(req), .x_i(xw), .y_i(yw), .cap_i(cap), .excite_i(excite),
        .data_o(sdat), .echo_o(echo));
    task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 d = rdat;
    endtask : rreg
    task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] s);
        num_checks++;
        if (s !== e) begin n_fail++; $display("unexpected %s: expected %h seen %h", n, e, s); end
    endtask : chk
    // Results settle well within 20 cycles of the tick
    task automatic tk;
        for (int i = 0; i < 300 && tick !== 1'b1; i++) @(negedge clk);
        repeat (20) @(posedge clk);
    endtask : tk
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rreg(OFF_TB_SETUP, v); chk("tb setup reset", RST_TB_SETUP, v);
        rreg(8'h24, v); chk("unmapped read", '0, v);
        wreg(OFF_PAR_MASK, 24'h07_FFFF);
        wreg(OFF_PAR_MAXC, 24'h00_0010);
        wreg(OFF_PAR_SETUP, 24'h38_FFD0);
        yw <= 24'hF8_0100;
        tk; tk; r1 = pres; chk("filtered step", 24'h00_0020, r1);
        tk; chk("filtered step", 24'h00_0030, pres);
        wreg(OFF_PAR_MASK, 24'hFF_FFFF);
        for (int i = 0; i < 4; i++) begin
            wreg(OFF_PAR_SETUP, rows[i][0]); xw <= rows[i][1]; yw <= rows[i][2];
            tk; chk("parallel result", rows[i][3], pres);
        end
        // Echo lands 103 clock edges after excitation; the 24-in-25 enable phase allows 98 or 99
        rreg(OFF_XDCR_TIME, v); chk("transducer time", 24'h00_0062 | (v & 24'h00_0001), v);
        $display("parallel tests done");
        wreg(OFF_TB_SETUP, 24'h40_0724);
        wreg(OFF_TB_SCALE, 24'h00_0200);
        xw <= 24'h00_1000; tk;
        xw <= 24'h00_1010; tk; chk("untriggered rate", 24'h00_4000, tbres);
        xw <= 24'h00_1008; tk; chk("untriggered rate", 24'hFF_E000, tbres);
        wreg(OFF_TB_SETUP, 24'h90_C000);
        tk; chk("frozen result", '0, tbres);
        chk("capture read", 24'h00_0001, {23'b0, cap_rd});
        rreg(OFF_TB_PREV, v); chk("saved previous", 24'h00_1008, v);
        wreg(OFF_TB_SETUP, 24'hB0_C000);
        cap <= 24'h00_0040; xw <= 24'h00_0048;
        tk; tk; chk("armed result", '0, tbres);
        trig <= 1'b1; tk; trig <= 1'b0;
        rreg(OFF_TB_SETUP, v); chk("running code", 24'hA0_C000, v);
        rreg(OFF_TB_PREV, v); chk("trigger reference", 24'h00_0800, v);
        tk; chk("running rate", 24'h04_2000, tbres);
        since <= 16'h0030;
        tk; chk("saturated rate", 24'h00_5C00, tbres);
        $display("time base tests done");
        test_done;
    end
    initial begin
        #400000;
        n_fail++;
        test_done;
    end
endmodule : test_feedback_timebase_convert
